// *** report_pkg.sv ***
/*
 * Shared constants for the reservation status report handler: structure
 * layout, record table sizing, status codes and action codes.
 * Assumes every user refers to items as report_pkg::name.
 */
package report_pkg;

   // ------------------------------------------------------------
   // Structure layout, in dwords
   // ------------------------------------------------------------
   localparam logic [31:0] HDR_BASE_DW = 32'h0000_0006;
   localparam logic [31:0] HDR_EXT_DW = 32'h0000_0010;
   localparam logic [3:0] REC_BASE_LAST = 4'h5;
   localparam logic [3:0] REC_EXT_LAST = 4'hF;
   localparam logic [31:0] REC_BASE_DW = 32'h0000_0006;
   localparam logic [31:0] REC_EXT_DW = 32'h0000_0010;
   localparam logic [31:0] DW_GEN = 32'h0000_0000;
   localparam logic [31:0] DW_KIND_COUNT = 32'h0000_0001;
   localparam logic [31:0] DW_PERSIST = 32'h0000_0002;

   // ------------------------------------------------------------
   // Command fields
   // ------------------------------------------------------------
   localparam int EXT_FLAG_BIT = 0;

   // ------------------------------------------------------------
   // Record table
   // ------------------------------------------------------------
   localparam int REC_AW = 4;
   localparam logic [15:0] MAX_RECS = 16'h0010;
   localparam int ENTRY_W = 18;
   localparam int HOLDER_BIT = 16;
   localparam int UNBOUND_BIT = 17;
   localparam logic [15:0] CONTROLLER_IDENTIFIER_UNBOUND = 16'hFFFF;

   // ------------------------------------------------------------
   // Status and action codes
   // ------------------------------------------------------------
   localparam logic [7:0] STATUS_SUCCESS = 8'h00;
   localparam logic [7:0] STATUS_HOSTID_FORMAT = 8'h01;
   localparam logic [2:0] RELEASE_CLEAR = 3'h1;
   localparam logic [2:0] ACQUIRE_PREEMPT = 3'h1;
   localparam logic [2:0] ACQUIRE_PREEMPT_ABORT = 3'h2;
   localparam logic [31:0] GEN_RESET = 32'h0000_0000;

endpackage

// *** record_if.sv ***
/*
 * Carrier between the handler and its record table: one write port and
 * one read port with a registered read result.
 * Assumes the report_pkg package is compiled first.
 */
`timescale 1ns/1ps
interface record_if;
   logic wr_en;
   logic [report_pkg::REC_AW-1:0] wr_addr;
   logic [report_pkg::ENTRY_W-1:0] wr_data;
   logic [report_pkg::REC_AW-1:0] rd_addr;
   logic [report_pkg::ENTRY_W-1:0] rd_data;

   modport user (
      output wr_en,
      output wr_addr,
      output wr_data,
      output rd_addr,
      input rd_data
   );

   modport store (
      input wr_en,
      input wr_addr,
      input wr_data,
      input rd_addr,
      output rd_data
   );
endinterface

// *** record_store.sv ***
/*
 * Table of registered controller entries, one per registrant-bound
 * controller. Read data come out of a register, one cycle after address.
 * Assumes a single clock shared with the handler.
 */
`timescale 1ns/1ps
module record_store (
   // Clock
   input wire logic clk,
   // Table access
   record_if.store port
);
   localparam int DEPTH = 1 << report_pkg::REC_AW;

   logic [report_pkg::ENTRY_W-1:0] mem [DEPTH];
   logic [report_pkg::ENTRY_W-1:0] rd_q;

   // Storage holds no control state, so it needs no reset
   always_ff @(posedge clk) begin
      if (port.wr_en) begin
         mem[port.wr_addr] <= port.wr_data;
      end
      rd_q <= mem[port.rd_addr];
   end

   assign port.rd_data = rd_q;
endmodule // record_store

// *** gen_counter.sv ***
/*
 * Wrapping per-namespace generation counter, bumped by successful registrations,
 * clearing releases and preempting acquires seen on any controller of the namespace.
 * Assumes each done strobe is a one-cycle pulse with its action code.
 */
`timescale 1ns/1ps
module gen_counter (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Completion events
   input wire logic register_done,
   input wire logic release_done,
   input wire logic [2:0] release_action_code,
   input wire logic acquire_done,
   input wire logic [2:0] acquire_action_code,
   // Count
   output logic [31:0] generation_counter
);
   logic [31:0] gen_q;
   logic [31:0] gen_d;
   logic inc_reg;
   logic inc_rel;
   logic inc_acq;

   always_comb begin
      inc_reg = register_done; // [R13]
      inc_rel = release_done &&
         (release_action_code == report_pkg::RELEASE_CLEAR); // [R14]
      inc_acq = acquire_done &&
         ((acquire_action_code == report_pkg::ACQUIRE_PREEMPT) ||
         (acquire_action_code == report_pkg::ACQUIRE_PREEMPT_ABORT)); // [R15]
      // Register, release and acquire may finish together; count each one
      gen_d = gen_q + {31'h0, inc_reg} + {31'h0, inc_rel} +
         {31'h0, inc_acq}; // [R12]
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         gen_q <= report_pkg::GEN_RESET;
      end else begin
         gen_q <= gen_d;
      end
   end

   assign generation_counter = gen_q;
endmodule // gen_counter

// *** reservation_report_handler.sv ***
/*
 * Reservation status report handler: takes one report command, checks
 * the structure format against the host identifier width, and streams the
 * base or extended status structure out as dwords, cut to the requested
 * length, then posts one completion.
 * Assumes buffer pointer decoding and queue posting live in other blocks;
 * the record table is filled by whatever tracks registrations.
 */
`timescale 1ns/1ps

// Functional notes
// R1: Command writes namespace registrant and reservation status to host memory.
// R2: Structure length grows with one record per registrant-bound controller; code caps it at MAX_RECS (16) records.
// R3: Base structure for 64-bit host identifier, extended for 128-bit.
// R4: 64-bit identifier with extended flag set aborts with format status.
// R5: 128-bit identifier with extended flag clear aborts with format status.
// R6: Parameters come in command dwords 10 and 11; rest reserved.
// R7: Host supplies destination buffer location in the buffer pointer field.
// R8: Dword 10 holds zero-based dword count; N requests N plus one.
// R9: Short request transfers only the leading part of the structure.
// R10: Long request transfers whole structure and nothing beyond it.
// R11: Dword 11 bit 0 selects extended format; other bits reserved.
// R12: Bytes 3..0 carry the wrapping 32-bit generation counter.
// R13: Counter increments on each successful registration command.
// R14: Counter increments on successful release with clear action.
// R15: Counter increments on successful acquire with preempt or preempt-abort.
// R16: Byte 4 reports reservation kind, zero when none is held.
// R17: Bytes 6..5 report registered controller count, equal to record count; code clamps the reported count to 16.
// R18: Base records are 24 bytes each starting at byte 24.
// R19: Extended: bytes 63..24 reserved, 64-byte records start at byte 64.
// R20: Record status bit 0 set when controller's host holds the reservation.
// R21: Record bytes 1..0 carry controller identifier, all ones if unbound.
// R22: Reserved bytes of the structure are written as zero.
// R23: After transfer or abort, a completion with the status is posted.
module reservation_report_handler (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Command
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [31:0] cmd_dword10,
   input wire logic [31:0] cmd_dword11,
   input wire logic host_id_extended,
   // Namespace state
   input wire logic [7:0] reservation_kind,
   input wire logic persist_state,
   input wire logic [15:0] registrant_count,
   // Record table write port
   input wire logic rec_wr_en,
   input wire logic [3:0] rec_wr_index,
   input wire logic [15:0] rec_wr_controller_identifier,
   input wire logic rec_wr_holder,
   input wire logic rec_wr_unbound,
   // Generation events
   input wire logic register_done,
   input wire logic release_done,
   input wire logic [2:0] release_action_code,
   input wire logic acquire_done,
   input wire logic [2:0] acquire_action_code,
   // Data stream towards host memory
   output logic out_valid,
   input wire logic out_ready,
   output logic [31:0] out_data,
   output logic [31:0] out_dword_index,
   output logic out_last,
   // Completion
   output logic cpl_valid,
   input wire logic cpl_ready,
   output logic [7:0] cpl_status,
   output logic [31:0] cpl_dwords,
   // Status
   output logic [31:0] generation_counter,
   output logic busy
);

   // ------------------------------------------------------------
   // Sub-blocks
   // ------------------------------------------------------------
   record_if rec ();

   record_store u_store (
      .clk(clk),
      .port(rec.store)
   );

   gen_counter u_gen (
      .clk(clk),
      .reset(reset),
      .register_done(register_done),
      .release_done(release_done),
      .release_action_code(release_action_code),
      .acquire_done(acquire_done),
      .acquire_action_code(acquire_action_code),
      .generation_counter(generation_counter)
   );

   assign rec.wr_en = rec_wr_en;
   assign rec.wr_addr = rec_wr_index;
   assign rec.wr_data = {rec_wr_unbound, rec_wr_holder,
      rec_wr_controller_identifier};

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FETCH,
      ST_LOAD,
      ST_SEND,
      ST_DONE
   } state_e;

   state_e state_q, state_d;
   logic [31:0] idx_q, idx_d;
   logic [31:0] len_q, len_d;
   logic [3:0] word_q, word_d;
   logic [3:0] rec_q, rec_d;
   logic ext_q, ext_d;
   logic [31:0] gen_snap_q, gen_snap_d;
   logic [7:0] kind_q, kind_d;
   logic [15:0] count_q, count_d;
   logic persist_q, persist_d;
   logic [31:0] data_q, data_d;
   logic [7:0] status_q, status_d;

   // Combinational helpers
   logic ext_flag;
   logic [15:0] count_clamp;
   logic [32:0] requested;
   logic [32:0] total;
   logic [31:0] hdr_dw;
   logic [3:0] rec_last;
   logic [15:0] entry_id;
   logic [31:0] dword_val;

   assign rec.rd_addr = rec_q;

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      idx_d = idx_q;
      len_d = len_q;
      word_d = word_q;
      rec_d = rec_q;
      ext_d = ext_q;
      gen_snap_d = gen_snap_q;
      kind_d = kind_q;
      count_d = count_q;
      persist_d = persist_q;
      data_d = data_q;
      status_d = status_q;

      ext_flag = cmd_dword11[report_pkg::EXT_FLAG_BIT]; // [R11] [R6]
      // Table holds a fixed number of entries; count never exceeds it
      count_clamp = (registrant_count > report_pkg::MAX_RECS) ?
         report_pkg::MAX_RECS : registrant_count; // [R17]
      // One bit wider so an all-ones count never wraps below the size
      requested = {1'b0, cmd_dword10} + 33'h0_0000_0001; // [R8]
      if (ext_flag) begin
         total = {1'b0, report_pkg::HDR_EXT_DW} +
            33'(count_clamp) * {1'b0, report_pkg::REC_EXT_DW}; // [R2] [R19]
      end else begin
         total = {1'b0, report_pkg::HDR_BASE_DW} +
            33'(count_clamp) * {1'b0, report_pkg::REC_BASE_DW}; // [R2] [R18]
      end

      hdr_dw = ext_q ? report_pkg::HDR_EXT_DW : report_pkg::HDR_BASE_DW;
      rec_last = ext_q ? report_pkg::REC_EXT_LAST :
         report_pkg::REC_BASE_LAST;
      entry_id = rec.rd_data[report_pkg::UNBOUND_BIT] ?
         report_pkg::CONTROLLER_IDENTIFIER_UNBOUND : rec.rd_data[15:0]; // [R21]

      // Dword value at idx_q; anything not named is reserved zero
      dword_val = 32'h0000_0000; // [R22]
      if (idx_q < hdr_dw) begin
         if (idx_q == report_pkg::DW_GEN) begin
            dword_val = gen_snap_q; // [R12]
         end else if (idx_q == report_pkg::DW_KIND_COUNT) begin
            dword_val = {8'h00, count_q, kind_q}; // [R16] [R17]
         end else if (idx_q == report_pkg::DW_PERSIST) begin
            dword_val = {16'h0000, 7'h00, persist_q, 8'h00};
         end
      end else if (word_q == 4'h0) begin
         dword_val = {8'h00, 7'h00, rec.rd_data[report_pkg::HOLDER_BIT],
            entry_id}; // [R20] [R21]
      end

      unique case (state_q)
         ST_IDLE: begin
            if (cmd_valid) begin
               idx_d = 32'h0000_0000;
               word_d = 4'h0;
               rec_d = 4'h0;
               ext_d = ext_flag; // [R3]
               // Header frozen at take so one report is self-consistent;
               // records are still read live from the table
               gen_snap_d = generation_counter;
               kind_d = reservation_kind;
               count_d = count_clamp;
               persist_d = persist_state;
               if (ext_flag != host_id_extended) begin
                  // Format mismatch: nothing is written to memory
                  status_d = report_pkg::STATUS_HOSTID_FORMAT; // [R4] [R5]
                  len_d = 32'h0000_0000;
                  state_d = ST_DONE;
               end else begin
                  status_d = report_pkg::STATUS_SUCCESS;
                  len_d = (requested < total) ? requested[31:0] :
                     total[31:0]; // [R9] [R10]
                  state_d = ST_FETCH;
               end
            end
         end
         ST_FETCH: begin
            // Table read address settles here; data valid next cycle
            state_d = ST_LOAD;
         end
         ST_LOAD: begin
            data_d = dword_val; // [R1]
            state_d = ST_SEND;
         end
         ST_SEND: begin
            if (out_ready) begin
               idx_d = idx_q + 32'h0000_0001;
               // Record position moves only once past the header
               if (idx_q >= hdr_dw) begin
                  if (word_q == rec_last) begin
                     word_d = 4'h0;
                     rec_d = rec_q + 4'h1; // [R18] [R19]
                  end else begin
                     word_d = word_q + 4'h1;
                  end
               end
               if (idx_q + 32'h0000_0001 == len_q) begin
                  state_d = ST_DONE; // [R10]
               end else begin
                  state_d = ST_FETCH;
               end
            end
         end
         ST_DONE: begin
            // Status and count stand until the queue side takes them
            if (cpl_ready) begin
               state_d = ST_IDLE; // [R23]
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q <= ST_IDLE;
         idx_q <= 32'h0000_0000;
         len_q <= 32'h0000_0000;
         word_q <= 4'h0;
         rec_q <= 4'h0;
         ext_q <= 1'b0;
         gen_snap_q <= 32'h0000_0000;
         kind_q <= 8'h00;
         count_q <= 16'h0000;
         persist_q <= 1'b0;
         data_q <= 32'h0000_0000;
         status_q <= 8'h00;
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
         len_q <= len_d;
         word_q <= word_d;
         rec_q <= rec_d;
         ext_q <= ext_d;
         gen_snap_q <= gen_snap_d;
         kind_q <= kind_d;
         count_q <= count_d;
         persist_q <= persist_d;
         data_q <= data_d;
         status_q <= status_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Handshakes decode the state; data come straight from flip-flops
   assign cmd_ready = (state_q == ST_IDLE);
   assign out_valid = (state_q == ST_SEND); // [R1]
   assign out_data = data_q;
   assign out_dword_index = idx_q;
   assign out_last = (state_q == ST_SEND) &&
      (idx_q + 32'h0000_0001 == len_q);
   assign cpl_valid = (state_q == ST_DONE); // [R23]
   assign cpl_status = status_q;
   assign cpl_dwords = len_q;
   assign busy = (state_q != ST_IDLE);

endmodule // reservation_report_handler

// *** report_handler_properties.sv ***
/*
 * Concurrent checks on the report handler's ports.
 * Assumes report_pkg is compiled first and one clock domain.
 */
`timescale 1ns/1ps
module report_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Command
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [31:0] cmd_dword11,
   input wire logic host_id_extended,
   // Generation events
   input wire logic register_done,
   input wire logic release_done,
   input wire logic [2:0] release_action_code,
   input wire logic acquire_done,
   input wire logic [2:0] acquire_action_code,
   // Stream and completion
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic [31:0] out_data,
   input wire logic [31:0] out_dword_index,
   input wire logic out_last,
   input wire logic cpl_valid,
   input wire logic cpl_ready,
   input wire logic [7:0] cpl_status,
   input wire logic [31:0] cpl_dwords,
   input wire logic [31:0] generation_counter,
   input wire logic busy
);
   logic take;
   logic fmt_bad;
   logic [1:0] gen_inc;
   assign take = cmd_valid && cmd_ready;
   assign fmt_bad = cmd_dword11[report_pkg::EXT_FLAG_BIT] != host_id_extended;
   always_comb begin
      gen_inc = 2'(register_done) + 2'(release_done &&
         release_action_code == report_pkg::RELEASE_CLEAR) +
         2'(acquire_done && (acquire_action_code == report_pkg::ACQUIRE_PREEMPT
         || acquire_action_code == report_pkg::ACQUIRE_PREEMPT_ABORT));
   end

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   // -------------------------------------------------------------
   // Handshake, stream, completion and generation counter checks
   // -------------------------------------------------------------
   sequence gap2;
      !out_valid ##1 !out_valid;
   endsequence

   take_busy_a: assert property (take |=> busy && !cmd_ready)
      else $error("busy not raised after take");
   fmt_abort_a: assert property (take && fmt_bad |=>
      cpl_valid && !out_valid
      && cpl_status == report_pkg::STATUS_HOSTID_FORMAT && cpl_dwords == 32'h0)
      else $error("format mismatch not aborted");
   fmt_pass_a: assert property (take && !fmt_bad |=> gap2 ##1
      out_valid && out_dword_index == 32'h0)
      else $error("first dword late or wrong");
   hold_data_a: assert property (out_valid && !out_ready |=> out_valid
      && $stable(out_data) && $stable(out_dword_index))
      else $error("stalled dword changed");
   next_index_a: assert property (out_valid && out_ready && !out_last
      |=> gap2 ##1 out_valid
      && out_dword_index == $past(out_dword_index, 3) + 32'h1)
      else $error("dword index did not step");
   last_cpl_a: assert property (out_valid && out_ready && out_last |=>
      cpl_valid && cpl_status == report_pkg::STATUS_SUCCESS
      && cpl_dwords == $past(out_dword_index) + 32'h1)
      else $error("completion after last dword wrong");
   cpl_hold_a: assert property (cpl_valid && !cpl_ready |=> cpl_valid
      && $stable(cpl_status) && $stable(cpl_dwords))
      else $error("completion not held");
   cpl_release_a: assert property (cpl_valid && cpl_ready |=>
      !cpl_valid && cmd_ready && !busy)
      else $error("no return to idle after completion");
   gen_step_a: assert property (1'b1 |=>
      generation_counter == $past(generation_counter)
      + 32'($past(gen_inc)))
      else $error("generation count step wrong");
   idle_quiet_a: assert property (!busy |-> !out_valid && !cpl_valid)
      else $error("output while idle");
endmodule // report_properties

bind reservation_report_handler report_properties u_props (.clk, .reset,
   .cmd_valid, .cmd_ready, .cmd_dword11, .host_id_extended, .register_done,
   .release_done, .release_action_code, .acquire_done, .acquire_action_code,
   .out_valid, .out_ready, .out_data, .out_dword_index, .out_last, .cpl_valid,
   .cpl_ready, .cpl_status, .cpl_dwords, .generation_counter, .busy);

// *** host_sink.sv ***
/*
 * Host memory and completion queue model: accepts dwords and completions,
 * promptly or one cycle in eight when slow.
 * Assumes the handler's clock and reset.
 */
`timescale 1ns/1ps
module host_sink (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Pace
   input wire logic slow,
   // Handler side
   input wire logic out_valid,
   input wire logic cpl_valid,
   output logic out_ready,
   output logic cpl_ready
);
   logic [2:0] pace_q;
   // Ready ignores valid on purpose, like a real sink with own pacing
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pace_q <= 3'h0;
         out_ready <= 1'b0;
         cpl_ready <= 1'b0;
      end else begin
         pace_q <= pace_q + 3'h1;
         out_ready <= !slow || pace_q == 3'h5;
         cpl_ready <= !slow || pace_q == 3'h2;
      end
   end
endmodule // host_sink

// *** tb_reservation_report_handler.sv ***
/*
 * Self-checking bench for the report handler with a host sink model.
 * Assumes report_pkg, the design, checker and sink are compiled first.
 */
`timescale 1ns/1ps
module tb_reservation_report_handler;
   logic clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, host_id_extended = 1'b0;
   logic [31:0] cmd_dword10 = 32'h0, cmd_dword11 = 32'h0, exp_gen = 32'h0;
   logic [7:0] reservation_kind = 8'h00;
   logic [15:0] registrant_count = 16'h0, rec_wr_controller_identifier = 16'h0;
   logic persist_state = 1'b0, rec_wr_en = 1'b0, rec_wr_holder = 1'b0;
   logic rec_wr_unbound = 1'b0, register_done = 1'b0, release_done = 1'b0;
   logic acquire_done = 1'b0, slow = 1'b0;
   logic [3:0] rec_wr_index = 4'h0;
   logic [2:0] release_action_code = 3'h0, acquire_action_code = 3'h0;
   logic cmd_ready, out_valid, out_ready, out_last, cpl_valid, cpl_ready, busy;
   logic [31:0] out_data, out_dword_index, cpl_dwords, generation_counter;
   logic [7:0] cpl_status;
   logic [63:0] dat_q [$];
   logic [39:0] cpl_q [$];
   logic [15:0] rnd = 16'h094A, holds = 16'h0, unbs = 16'h0;
   logic [15:0] ids [16];
   logic [7:0] flag_tab = 8'b0001_1100, hx_tab = 8'b0010_1100;
   logic [31:0] n_tab [8] = '{32'h2, 32'hFFFF_FFFF, 32'h28, 32'hFFFF_FFFF,
      32'h5, 32'h5, 32'h5, 32'h3E8};
   logic [15:0] cnt_tab [8] = '{16'h3, 16'h3, 16'h2, 16'h10, 16'h3, 16'h3,
      16'h0, 16'h14};
   logic [7:0] kind_tab [8] = '{8'h01, 8'h03, 8'h00, 8'h05, 8'h01, 8'h01,
      8'h00, 8'h02};
   int error_cnt = 0;
   int compares = 0;

   always #12.5 clk = ~clk;

   reservation_report_handler u_dut (.clk, .reset, .cmd_valid, .cmd_ready,
      .cmd_dword10, .cmd_dword11, .host_id_extended, .reservation_kind,
      .persist_state, .registrant_count, .rec_wr_en, .rec_wr_index,
      .rec_wr_controller_identifier, .rec_wr_holder, .rec_wr_unbound,
      .register_done, .release_done, .release_action_code, .acquire_done,
      .acquire_action_code, .out_valid, .out_ready, .out_data,
      .out_dword_index, .out_last, .cpl_valid, .cpl_ready, .cpl_status,
      .cpl_dwords, .generation_counter, .busy);
   host_sink u_sink (.clk, .reset, .slow, .out_valid, .cpl_valid, .out_ready,
      .cpl_ready);

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected value at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Records have the header's size in both forms
   function automatic logic [31:0] exp_dword(input logic [31:0] k,
         input logic [31:0] hdr, input logic [4:0] c);
      logic [31:0] r;
      if (k == 32'h0) return exp_gen;
      if (k == 32'h1) return {8'h00, 11'h0, c, reservation_kind};
      if (k == 32'h2) return {23'h0, persist_state, 8'h00};
      if (k < hdr || (k - hdr) % hdr != 32'h0) return 32'h0;
      r = (k - hdr) / hdr;
      return {15'h0, holds[r[3:0]], unbs[r[3:0]] ? 16'hFFFF : ids[r[3:0]]};
   endfunction

   task automatic run(input int t);
      logic [32:0] len;
      logic [31:0] hdr;
      logic [4:0] c;
      logic f, hx;
      f = flag_tab[t];
      hx = hx_tab[t];
      c = (cnt_tab[t] > 16'h10) ? 5'h10 : cnt_tab[t][4:0];
      hdr = f ? 32'h10 : 32'h6;
      @(posedge clk);
      rnd = lfsr(rnd);
      slow <= t[0];
      reservation_kind <= kind_tab[t];
      persist_state <= rnd[5];
      registrant_count <= cnt_tab[t];
      cmd_dword10 <= n_tab[t];
      cmd_dword11 <= {rnd, rnd[14:0], f};
      host_id_extended <= hx;
      @(posedge clk);
      len = 33'(hdr) * 33'(c) + 33'(hdr);
      if (33'(n_tab[t]) + 33'h1 < len) len = 33'(n_tab[t]) + 33'h1;
      if (f != hx) len = 33'h0;
      for (int k = 0; k < int'(len); k++)
         dat_q.push_back({32'(k), exp_dword(32'(k), hdr, c)});
      cpl_q.push_back({(f != hx) ? report_pkg::STATUS_HOSTID_FORMAT :
         report_pkg::STATUS_SUCCESS, len[31:0]});
      cmd_valid <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         if (cmd_ready) break;
      end
      cmd_valid <= 1'b0;
      for (int i = 0; i < 4000; i++) begin
         @(posedge clk);
         if (cpl_valid && cpl_ready) break;
      end
      // Let the monitor pop this edge's completion first
      @(negedge clk);
      check(64'(dat_q.size() + cpl_q.size()), 64'h0);
   endtask

   always @(posedge clk) begin
      if (out_valid && out_ready) begin
         check(64'(out_last), 64'(dat_q.size() == 1));
         check({out_dword_index, out_data}, dat_q.pop_front());
      end
      if (cpl_valid && cpl_ready)
         check({cpl_status, cpl_dwords}, cpl_q.pop_front());
   end

   initial begin
      #1500000;
      error_cnt++;
      $display("watchdog expired at %0t", $time);
      end_of_test();
   end

   initial begin
      logic rl, aq;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      check({busy, cmd_ready, out_valid, cpl_valid, generation_counter},
         {4'b0100, 32'h0});
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         rnd = lfsr(rnd);
         ids[i] = rnd;
         holds[i] = rnd[3];
         unbs[i] = (i == 5);
         rec_wr_en <= 1'b1;
         rec_wr_index <= 4'(i);
         rec_wr_controller_identifier <= rnd;
         rec_wr_holder <= rnd[3];
         rec_wr_unbound <= (i == 5);
      end
      @(posedge clk);
      rec_wr_en <= 1'b0;
      for (int i = 0; i < 25; i++) begin
         @(posedge clk);
         rnd = lfsr(rnd);
         rl = rnd[1] || i == 1;
         aq = rnd[2] || i == 2 || i == 9;
         register_done <= rnd[0] && i < 24;
         release_done <= rl && i < 24;
         acquire_done <= aq && i < 24;
         release_action_code <= 3'(i);
         acquire_action_code <= 3'(i);
         if (i < 24) exp_gen += 32'(rnd[0]) + 32'(rl && i % 8 == 1) +
            32'(aq && (i % 8 == 1 || i % 8 == 2));
      end
      @(posedge clk);
      check(generation_counter, exp_gen);
      $display("test events done");
      for (int t = 0; t < 8; t++) begin
         run(t);
         $display("test report %0d done", t);
      end
      end_of_test();
   end
endmodule // tb_reservation_report_handler
